// file: inc/fgcu_params.svh
`ifndef FGCU_PARAMS_SVH
`define FGCU_PARAMS_SVH

// Register bus geometry
`define FGCU_ADDR_W 8
`define FGCU_DATA_W 32
`define FGCU_GRP_N 8

// Register offsets
`define FGCU_OFF_CMD 8'h00
`define FGCU_OFF_STATUS 8'h04
`define FGCU_OFF_RESULT 8'h08
`define FGCU_OFF_CTRL 8'h0C
`define FGCU_OFF_FROZEN 8'h10
`define FGCU_OFF_SYNCED 8'h14
`define FGCU_OFF_COUNT 8'h18

// Command word fields
`define FGCU_CMD_CH_LSB 0
`define FGCU_CMD_FCT_LSB 8
`define FGCU_CMD_MASK_LSB 16

// Status bits
`define FGCU_ST_ERR 0
`define FGCU_ST_BUSY 1
`define FGCU_ST_AUTO 2
`define FGCU_ST_CAUSE_CH 4
`define FGCU_ST_CAUSE_BUSY 5
`define FGCU_ST_CAUSE_FCT 6

// Control bits and reset value
`define FGCU_CT_AUTO_EN 0
`define FGCU_CT_CH9_ON 1
`define FGCU_CT_CH8_ON 2
`define FGCU_CTRL_RST 3'h7

// Channels and function codes
`define FGCU_CH_PRI 8'h09
`define FGCU_CH_SEC 8'h08
`define FGCU_FC_XIN 8'h0A
`define FGCU_FC_XOUT 8'h0B
`define FGCU_FC_XALL 8'h0C
`define FGCU_FC_FREEZE 8'h0D
`define FGCU_FC_UNFREEZE 8'h0E
`define FGCU_FC_SYNC 8'h0F
`define FGCU_FC_UNSYNC 8'h10

// Outcome codes and the all-groups mask
`define FGCU_RES_RST 8'h00
`define FGCU_RES_EMPTY 8'h00
`define FGCU_ALL_GRP 8'hFF

`endif

// file: inc/fgcu_pkg.sv
package fgcu_pkg;

    typedef enum logic [1:0] {
        GC_FREEZE,
        GC_UNFREEZE,
        GC_SYNC,
        GC_UNSYNC
    } fgcu_gc_kind_t;

    typedef enum logic [0:0] {
        GC_IDLE,
        GC_WAIT
    } fgcu_gc_state_t;

endpackage : fgcu_pkg

// file: src/fgcu_gc_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "fgcu_params.svh"

module fgcu_gc_engine #(
    parameter int GRP_N = `FGCU_GRP_N
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Start from the command decoder
    input wire logic start_i,
    input wire fgcu_pkg::fgcu_gc_kind_t kind_i,
    input wire logic [GRP_N-1:0] mask_i,
    // Service towards the bus engine
    output logic gc_req_o,
    output fgcu_pkg::fgcu_gc_kind_t gc_kind_o,
    output logic [GRP_N-1:0] gc_grp_o,
    input wire logic gc_done_i,
    input wire logic [7:0] gc_result_i,
    // Progress
    output logic busy_o,
    output logic done_o,
    output logic [7:0] result_o
);

    fgcu_pkg::fgcu_gc_state_t state_ff;
    fgcu_pkg::fgcu_gc_kind_t kind_ff;
    logic [GRP_N-1:0] grp_ff;
    logic done_ff;
    logic [7:0] result_ff;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= fgcu_pkg::GC_IDLE;
            kind_ff <= fgcu_pkg::GC_FREEZE;
            grp_ff <= '0;
        end else if (ce_i) begin
            case (state_ff)
                fgcu_pkg::GC_IDLE: begin
                    // Empty mask completes at once and sends nothing
                    if (start_i && (mask_i != '0)) begin
                        state_ff <= fgcu_pkg::GC_WAIT;
                        kind_ff <= kind_i;
                        grp_ff <= mask_i;
                    end
                end
                fgcu_pkg::GC_WAIT: begin
                    if (gc_done_i) begin
                        state_ff <= fgcu_pkg::GC_IDLE;
                    end
                end
                default: state_ff <= fgcu_pkg::GC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_ff <= 1'b0;
            result_ff <= `FGCU_RES_RST;
        end else if (ce_i) begin
            done_ff <= 1'b0;
            if (state_ff == fgcu_pkg::GC_WAIT && gc_done_i) begin
                done_ff <= 1'b1;
                result_ff <= gc_result_i;
            end else if (state_ff == fgcu_pkg::GC_IDLE && start_i && (mask_i == '0)) begin
                result_ff <= `FGCU_RES_EMPTY;
            end
        end
    end

    // Request holds until the bus engine reports the outcome
    assign gc_req_o = (state_ff == fgcu_pkg::GC_WAIT);
    assign gc_kind_o = kind_ff;
    assign gc_grp_o = grp_ff;
    assign busy_o = (state_ff == fgcu_pkg::GC_WAIT);
    assign done_o = done_ff;
    assign result_o = result_ff;

endmodule : fgcu_gc_engine
`default_nettype wire

// file: src/fgcu_group_state.sv
`timescale 1ns/1ps
`default_nettype none
`include "fgcu_params.svh"

module fgcu_group_state #(
    parameter int GRP_N = `FGCU_GRP_N
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Completed global control
    input wire logic done_i,
    input wire fgcu_pkg::fgcu_gc_kind_t kind_i,
    input wire logic [GRP_N-1:0] grp_i,
    // Per-group view
    output logic [GRP_N-1:0] frozen_o,
    output logic [GRP_N-1:0] synced_o
);

    logic [GRP_N-1:0] frozen_ff;
    logic [GRP_N-1:0] synced_ff;

    genvar g;
    generate
        for (g = 0; g < GRP_N; g++) begin : gen_grp
            // Repeated freeze or sync keeps the group in that state
            always_ff @(posedge clock_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    frozen_ff[g] <= 1'b0;
                    synced_ff[g] <= 1'b0;
                end else if (ce_i && done_i && grp_i[g]) begin
                    case (kind_i)
                        fgcu_pkg::GC_FREEZE: frozen_ff[g] <= 1'b1;
                        fgcu_pkg::GC_UNFREEZE: frozen_ff[g] <= 1'b0;
                        fgcu_pkg::GC_SYNC: synced_ff[g] <= 1'b1;
                        fgcu_pkg::GC_UNSYNC: synced_ff[g] <= 1'b0;
                        default: frozen_ff[g] <= frozen_ff[g];
                    endcase
                end
            end
        end
    endgenerate

    assign frozen_o = frozen_ff;
    assign synced_o = synced_ff;

endmodule : fgcu_group_state
`default_nettype wire

// file: src/fgcu_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fgcu_params.svh"

module fgcu_top #(
    parameter int GRP_N = `FGCU_GRP_N,
    parameter int CNT_W = 16
) (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [`FGCU_ADDR_W-1:0] addr_i,
    input wire logic [`FGCU_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`FGCU_DATA_W-1:0] rdata_o,
    // Program cycle markers
    input wire logic cycle_start_i,
    input wire logic cycle_end_i,
    // Image exchange requests
    output logic xchg_in_o,
    output logic [GRP_N-1:0] xchg_in_grp_o,
    output logic xchg_out_o,
    output logic [GRP_N-1:0] xchg_out_grp_o,
    // Global control service
    output logic gc_req_o,
    output fgcu_pkg::fgcu_gc_kind_t gc_kind_o,
    output logic [GRP_N-1:0] gc_grp_o,
    input wire logic gc_done_i,
    input wire logic [7:0] gc_result_i,
    // Flags
    output logic busy_o,
    output logic error_o
);

    // Command fields
    logic cmd_wr;
    logic [7:0] cmd_ch;
    logic [7:0] cmd_fct;
    logic [GRP_N-1:0] cmd_mask;
    logic ch_ok;
    logic fct_xchg;
    logic fct_gc;
    logic acc_xchg;
    logic acc_gc;
    logic rej_ch;
    logic rej_busy;
    logic rej_fct;
    logic rej_any;
    fgcu_pkg::fgcu_gc_kind_t cmd_kind;

    // State
    logic [2:0] ctrl_ff;
    logic err_ff;
    logic cause_ch_ff;
    logic cause_busy_ff;
    logic cause_fct_ff;
    logic err_clr;
    logic xin_ff;
    logic xout_ff;
    logic [GRP_N-1:0] xin_grp_ff;
    logic [GRP_N-1:0] xout_grp_ff;
    logic [CNT_W-1:0] acc_cnt_ff;
    logic [CNT_W-1:0] rej_cnt_ff;
    logic [`FGCU_DATA_W-1:0] rdata_ff;
    logic [`FGCU_DATA_W-1:0] nxt_rdata;

    // Forced and automatic exchange terms
    logic frc_in;
    logic frc_out;
    logic auto_in;
    logic auto_out;

    // Engine wiring
    logic busy;
    logic gc_done;
    logic [7:0] result;
    logic [GRP_N-1:0] frozen;
    logic [GRP_N-1:0] synced;

    // Command decode
    assign cmd_wr = wr_i && (addr_i == `FGCU_OFF_CMD);
    assign cmd_ch = wdata_i[`FGCU_CMD_CH_LSB +: 8];
    assign cmd_fct = wdata_i[`FGCU_CMD_FCT_LSB +: 8];
    assign cmd_mask = wdata_i[`FGCU_CMD_MASK_LSB +: GRP_N];

    assign ch_ok = ((cmd_ch == `FGCU_CH_PRI) && ctrl_ff[`FGCU_CT_CH9_ON])
                || ((cmd_ch == `FGCU_CH_SEC) && ctrl_ff[`FGCU_CT_CH8_ON]);

    assign fct_xchg = (cmd_fct == `FGCU_FC_XIN) || (cmd_fct == `FGCU_FC_XOUT)
                   || (cmd_fct == `FGCU_FC_XALL);
    assign fct_gc = (cmd_fct == `FGCU_FC_FREEZE) || (cmd_fct == `FGCU_FC_UNFREEZE)
                 || (cmd_fct == `FGCU_FC_SYNC) || (cmd_fct == `FGCU_FC_UNSYNC);

    // Exchange ignores busy entirely
    assign acc_xchg = cmd_wr && ch_ok && fct_xchg;
    assign acc_gc = cmd_wr && ch_ok && fct_gc && !busy;

    assign rej_ch = cmd_wr && !ch_ok;
    assign rej_fct = cmd_wr && ch_ok && !fct_xchg && !fct_gc;
    assign rej_busy = cmd_wr && ch_ok && fct_gc && busy;
    assign rej_any = rej_ch || rej_fct || rej_busy;

    always_comb begin
        cmd_kind = fgcu_pkg::GC_FREEZE;
        if (cmd_fct == `FGCU_FC_UNFREEZE) begin
            cmd_kind = fgcu_pkg::GC_UNFREEZE;
        end else if (cmd_fct == `FGCU_FC_SYNC) begin
            cmd_kind = fgcu_pkg::GC_SYNC;
        end else if (cmd_fct == `FGCU_FC_UNSYNC) begin
            cmd_kind = fgcu_pkg::GC_UNSYNC;
        end
    end

    // Control register
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_ff <= `FGCU_CTRL_RST;
        end else if (ce_i && wr_i && (addr_i == `FGCU_OFF_CTRL)) begin
            ctrl_ff <= wdata_i[2:0];
        end
    end

    // Error flag: writing one to the error bit clears it, a new error wins
    assign err_clr = wr_i && (addr_i == `FGCU_OFF_STATUS) && wdata_i[`FGCU_ST_ERR];

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            err_ff <= 1'b0;
            cause_ch_ff <= 1'b0;
            cause_busy_ff <= 1'b0;
            cause_fct_ff <= 1'b0;
        end else if (ce_i) begin
            if (rej_any) begin
                err_ff <= 1'b1;
            end else if (err_clr) begin
                err_ff <= 1'b0;
            end
            if (rej_ch) begin
                cause_ch_ff <= 1'b1;
            end else if (err_clr) begin
                cause_ch_ff <= 1'b0;
            end
            if (rej_busy) begin
                cause_busy_ff <= 1'b1;
            end else if (err_clr) begin
                cause_busy_ff <= 1'b0;
            end
            if (rej_fct) begin
                cause_fct_ff <= 1'b1;
            end else if (err_clr) begin
                cause_fct_ff <= 1'b0;
            end
        end
    end

    // Forced exchange: all masked groups in one pulse, none when mask is empty
    assign frc_in = acc_xchg && (cmd_mask != '0)
                 && ((cmd_fct == `FGCU_FC_XIN) || (cmd_fct == `FGCU_FC_XALL));
    assign frc_out = acc_xchg && (cmd_mask != '0)
                  && ((cmd_fct == `FGCU_FC_XOUT) || (cmd_fct == `FGCU_FC_XALL));

    // Automatic copy at the program cycle boundaries
    assign auto_in = ctrl_ff[`FGCU_CT_AUTO_EN] && cycle_start_i;
    assign auto_out = ctrl_ff[`FGCU_CT_AUTO_EN] && cycle_end_i;

    // A forced and an automatic request in one cycle merge into one pulse
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            xin_ff <= 1'b0;
            xin_grp_ff <= '0;
        end else if (ce_i) begin
            xin_ff <= frc_in || auto_in;
            if (auto_in) begin
                xin_grp_ff <= GRP_N'(`FGCU_ALL_GRP);
            end else if (frc_in) begin
                xin_grp_ff <= cmd_mask;
            end else begin
                xin_grp_ff <= '0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            xout_ff <= 1'b0;
            xout_grp_ff <= '0;
        end else if (ce_i) begin
            // Output image still goes out to synced groups; slaves hold it
            xout_ff <= frc_out || auto_out;
            if (auto_out) begin
                xout_grp_ff <= GRP_N'(`FGCU_ALL_GRP);
            end else if (frc_out) begin
                xout_grp_ff <= cmd_mask;
            end else begin
                xout_grp_ff <= '0;
            end
        end
    end

    // Command statistics, wrap silently
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_cnt_ff <= '0;
            rej_cnt_ff <= '0;
        end else if (ce_i) begin
            if (acc_xchg || acc_gc) begin
                acc_cnt_ff <= acc_cnt_ff + 1'b1;
            end
            if (rej_any) begin
                rej_cnt_ff <= rej_cnt_ff + 1'b1;
            end
        end
    end

    // Global control engine; a refused start never reaches it
    fgcu_gc_engine #(
        .GRP_N(GRP_N)
    ) u_gc (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .start_i(acc_gc),
        .kind_i(cmd_kind),
        .mask_i(cmd_mask),
        .gc_req_o(gc_req_o),
        .gc_kind_o(gc_kind_o),
        .gc_grp_o(gc_grp_o),
        .gc_done_i(gc_done_i),
        .gc_result_i(gc_result_i),
        .busy_o(busy),
        .done_o(gc_done),
        .result_o(result)
    );

    // Tracks which groups are frozen or synced on the far side
    fgcu_group_state #(
        .GRP_N(GRP_N)
    ) u_grp (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .done_i(gc_done),
        .kind_i(gc_kind_o),
        .grp_i(gc_grp_o),
        .frozen_o(frozen),
        .synced_o(synced)
    );

    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = '0;
        if (addr_i == `FGCU_OFF_STATUS) begin
            nxt_rdata[`FGCU_ST_ERR] = err_ff;
            nxt_rdata[`FGCU_ST_BUSY] = busy;
            nxt_rdata[`FGCU_ST_AUTO] = ctrl_ff[`FGCU_CT_AUTO_EN];
            nxt_rdata[`FGCU_ST_CAUSE_CH] = cause_ch_ff;
            nxt_rdata[`FGCU_ST_CAUSE_BUSY] = cause_busy_ff;
            nxt_rdata[`FGCU_ST_CAUSE_FCT] = cause_fct_ff;
        end else if (addr_i == `FGCU_OFF_RESULT) begin
            nxt_rdata[7:0] = result;
        end else if (addr_i == `FGCU_OFF_CTRL) begin
            nxt_rdata[2:0] = ctrl_ff;
        end else if (addr_i == `FGCU_OFF_FROZEN) begin
            nxt_rdata[GRP_N-1:0] = frozen;
        end else if (addr_i == `FGCU_OFF_SYNCED) begin
            nxt_rdata[GRP_N-1:0] = synced;
        end else if (addr_i == `FGCU_OFF_COUNT) begin
            nxt_rdata[CNT_W-1:0] = acc_cnt_ff;
            nxt_rdata[2*CNT_W-1:CNT_W] = rej_cnt_ff;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= '0;
        end else if (ce_i) begin
            rdata_ff <= rd_i ? nxt_rdata : '0;
        end
    end

    // Outputs
    assign rdata_o = rdata_ff;
    assign xchg_in_o = xin_ff;
    assign xchg_in_grp_o = xin_grp_ff;
    assign xchg_out_o = xout_ff;
    assign xchg_out_grp_o = xout_grp_ff;
    assign busy_o = busy;
    assign error_o = err_ff;

endmodule : fgcu_top
`default_nettype wire

// file: sim/fgcu_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "fgcu_params.svh"
module fgcu_top_monitor #(
    parameter int GRP_N = 8,
    parameter int CNT_W = 16
) (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [`FGCU_ADDR_W-1:0] addr_i,
    input wire logic [`FGCU_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [`FGCU_DATA_W-1:0] rdata_o,
    // Cycle markers and exchange
    input wire logic cycle_start_i,
    input wire logic cycle_end_i,
    input wire logic xchg_in_o,
    input wire logic [GRP_N-1:0] xchg_in_grp_o,
    input wire logic xchg_out_o,
    input wire logic [GRP_N-1:0] xchg_out_grp_o,
    // Global control
    input wire logic gc_req_o,
    input wire fgcu_pkg::fgcu_gc_kind_t gc_kind_o,
    input wire logic [GRP_N-1:0] gc_grp_o,
    input wire logic gc_done_i,
    input wire logic [7:0] gc_result_i,
    // Flags
    input wire logic busy_o,
    input wire logic error_o
);
    logic [2:0] ctrl_ff;
    wire logic cmd_w = ce_i && wr_i && addr_i == `FGCU_OFF_CMD;
    wire logic [7:0] ch = wdata_i[7:0];
    wire logic [7:0] fc = wdata_i[15:8];
    wire logic [GRP_N-1:0] mk = wdata_i[`FGCU_CMD_MASK_LSB +: GRP_N];
    wire logic ch_ok = (ch == `FGCU_CH_PRI && ctrl_ff[1]) || (ch == `FGCU_CH_SEC && ctrl_ff[2]);
    wire logic gc_cmd = cmd_w && ch_ok && fc >= `FGCU_FC_FREEZE && fc <= `FGCU_FC_UNSYNC;
    wire logic go_cmd = gc_cmd && !busy_o && mk != '0;
    // Mirror of the control register, so channel assignment is judged as the block sees it
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_ff <= `FGCU_CTRL_RST;
        end else if (ce_i && wr_i && addr_i == `FGCU_OFF_CTRL) begin
            ctrl_ff <= wdata_i[2:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    property p_busy_req; busy_o == gc_req_o && (!busy_o || gc_grp_o != '0); endproperty
    a_busy_req: assert property (p_busy_req) else $error("busy differs from pending service");
    property p_gc_start;
        go_cmd |=> gc_req_o && gc_grp_o == $past(mk) && gc_kind_o == ($past(fc[1:0]) - 2'h1);
    endproperty
    a_gc_start: assert property (p_gc_start) else $error("global control not started");
    property p_gc_rej;
        gc_cmd && busy_o && !gc_done_i |=> error_o && busy_o && $stable(gc_grp_o) && $stable(gc_kind_o);
    endproperty
    a_gc_rej: assert property (p_gc_rej) else $error("command while busy not refused");
    property p_release; ce_i && busy_o && gc_done_i |=> !busy_o; endproperty
    a_release: assert property (p_release) else $error("busy kept after completion");
    property p_gc_empty; gc_cmd && !busy_o && mk == '0 |=> !gc_req_o [*2]; endproperty
    a_gc_empty: assert property (p_gc_empty) else $error("service sent for empty mask");
    property p_xin;
        cmd_w && ch_ok && (fc == `FGCU_FC_XIN || fc == `FGCU_FC_XALL) && mk != '0 && !cycle_start_i
        |=> xchg_in_o && xchg_in_grp_o == $past(mk);
    endproperty
    a_xin: assert property (p_xin) else $error("input exchange missing");
    property p_xout;
        cmd_w && ch_ok && (fc == `FGCU_FC_XOUT || fc == `FGCU_FC_XALL) && mk != '0 && !cycle_end_i
        |=> xchg_out_o && xchg_out_grp_o == $past(mk);
    endproperty
    a_xout: assert property (p_xout) else $error("output exchange missing");
    property p_bad_ch; cmd_w && !ch_ok |=> error_o; endproperty
    a_bad_ch: assert property (p_bad_ch) else $error("unassigned channel accepted");
    property p_auto; ce_i && cycle_start_i && ctrl_ff[0] |=> xchg_in_o && xchg_in_grp_o == '1; endproperty
    a_auto: assert property (p_auto) else $error("automatic input copy missing");
    property p_x_empty;
        cmd_w && mk == '0 && !cycle_start_i && !cycle_end_i |=> !xchg_in_o && !xchg_out_o;
    endproperty
    a_x_empty: assert property (p_x_empty) else $error("exchange sent for empty mask");
    property p_req_cause; $rose(gc_req_o) |-> $past(go_cmd); endproperty
    a_req_cause: assert property (p_req_cause) else $error("service without accepted command");
    c_done: cover property (busy_o && gc_done_i);
    c_rej: cover property (gc_cmd && busy_o);
    c_auto: cover property (cycle_start_i && ctrl_ff[0]);
endmodule : fgcu_top_monitor
bind fgcu_top fgcu_top_monitor #(.GRP_N(GRP_N), .CNT_W(CNT_W)) u_mon (.clock_i, .sys_rst_i, .ce_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .cycle_start_i, .cycle_end_i, .xchg_in_o, .xchg_in_grp_o, .xchg_out_o,
    .xchg_out_grp_o, .gc_req_o, .gc_kind_o, .gc_grp_o, .gc_done_i, .gc_result_i, .busy_o, .error_o);
`default_nettype wire

// file: sim/fgcu_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module fgcu_slave_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Service request
    input wire logic gc_req_i,
    input wire fgcu_pkg::fgcu_gc_kind_t gc_kind_i,
    input wire logic [7:0] gc_grp_i,
    // Answer delay and outcome
    input wire logic [7:0] delay_i,
    input wire logic [7:0] res_i,
    // Answer
    output logic gc_done_o,
    output logic [7:0] gc_result_o
);
    logic [7:0] cnt_ff, res_ff, frozen_ff, synced_ff;
    logic answered_ff;
    // Outcome is only valid beside done; otherwise it shows a changed value
    assign gc_result_o = gc_done_o ? res_ff : ~res_ff;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_ff <= 8'h00;
            res_ff <= 8'h00;
            frozen_ff <= 8'h00;
            synced_ff <= 8'h00;
            answered_ff <= 1'b0;
            gc_done_o <= 1'b0;
        end else begin
            gc_done_o <= 1'b0;
            if (!gc_req_i) begin
                cnt_ff <= 8'h00;
                answered_ff <= 1'b0;
            end else if (!answered_ff && cnt_ff >= delay_i) begin
                gc_done_o <= 1'b1;
                answered_ff <= 1'b1;
                res_ff <= res_i;
                case (gc_kind_i)
                    fgcu_pkg::GC_FREEZE: frozen_ff <= frozen_ff | gc_grp_i;
                    fgcu_pkg::GC_UNFREEZE: frozen_ff <= frozen_ff & ~gc_grp_i;
                    fgcu_pkg::GC_SYNC: synced_ff <= synced_ff | gc_grp_i;
                    default: synced_ff <= synced_ff & ~gc_grp_i;
                endcase
            end else if (!answered_ff) begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end
endmodule : fgcu_slave_model
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fgcu_params.svh"
module tb_top;
    logic clock_i = 0, sys_rst_i = 1, ce_i = 1, wr_i = 0, rd_i = 0, cycle_start_i = 0, cycle_end_i = 0;
    logic [7:0] addr_i = 8'h00, dly = 8'h06, res = 8'h00, gc_grp_o, xin_g, xout_g, gc_result_i;
    logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
    logic xchg_in_o, xchg_out_o, gc_req_o, gc_done_i, busy_o, error_o;
    fgcu_pkg::fgcu_gc_kind_t gc_kind_o;
    int mismatches = 0, checks_done = 0;
    initial forever #2.5 clock_i = ~clock_i;
    fgcu_top i_dut (.clock_i, .sys_rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cycle_start_i,
        .cycle_end_i, .xchg_in_o, .xchg_in_grp_o(xin_g), .xchg_out_o, .xchg_out_grp_o(xout_g), .gc_req_o,
        .gc_kind_o, .gc_grp_o, .gc_done_i, .gc_result_i, .busy_o, .error_o);
    fgcu_slave_model i_far (.clock_i, .sys_rst_i, .gc_req_i(gc_req_o), .gc_kind_i(gc_kind_o),
        .gc_grp_i(gc_grp_o), .delay_i(dly), .res_i(res), .gc_done_o(gc_done_i), .gc_result_o(gc_result_i));
    task compare(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : compare
    task results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask : reg_wr
    task reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        compare(rdata_o, exp, what);
    endtask : reg_rd
    task cmd(input logic [7:0] ch, input logic [7:0] fc, input logic [7:0] mk);
        reg_wr(`FGCU_OFF_CMD, {8'h00, mk, fc, ch});
    endtask : cmd
    task clear_err;
        reg_wr(`FGCU_OFF_STATUS, 32'h0000_0001);
        compare(error_o, 0, "error clear");
    endtask : clear_err
    task t_regs;
        reg_rd(`FGCU_OFF_STATUS, 32'h0000_0004, "status reset");
        reg_rd(`FGCU_OFF_RESULT, 0, "result reset");
        reg_rd(`FGCU_OFF_CTRL, 32'h0000_0007, "ctrl reset");
        reg_rd(`FGCU_OFF_CMD, 0, "cmd reads zero");
        reg_rd(8'h1C, 0, "unmapped read");
    endtask : t_regs
    task t_exchange;
        logic [7:0] m;
        for (int i = 0; i < 4; i++) begin
            m = (i == 3) ? 8'h00 : (i == 1) ? 8'h80 : (i == 2) ? 8'hFF : 8'h03;
            cmd(i[0] ? 8'h08 : 8'h09, 8'h0A + 8'(i % 3), m); // Last pass repeats code 10 with empty mask
            compare(xchg_in_o, i != 1 && m != 0, "in pulse");
            compare(xin_g, (i != 1) ? m : 8'h00, "in groups");
            compare(xchg_out_o, i == 1 || i == 2, "out pulse");
            compare(xout_g, (i == 1 || i == 2) ? m : 8'h00, "out groups");
        end
        compare(error_o, 0, "no error");
    endtask : t_exchange
    task t_gc;
        static logic [7:0] fcs [6] = '{8'h0D, 8'h0D, 8'h0E, 8'h0F, 8'h0F, 8'h10};
        static logic [7:0] ms [6] = '{8'h10, 8'h03, 8'h10, 8'h04, 8'h0C, 8'h0C};
        static logic [7:0] fz [6] = '{8'h10, 8'h13, 8'h03, 8'h03, 8'h03, 8'h03};
        static logic [7:0] sy [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h0C, 8'h00};
        int n;
        for (int i = 0; i < 6; i++) begin
            dly <= i[0] ? 8'h00 : 8'h06; // Prompt and slow answers alternate
            res <= 8'h40 + 8'(i);
            cmd(8'h09, fcs[i], ms[i]);
            compare(busy_o, 1, "busy raised");
            compare(gc_grp_o, ms[i], "service groups");
            compare(gc_kind_o, fcs[i] - 8'h0D, "service kind");
            if (i == 0) begin
                cmd(8'h09, 8'h10, 8'hFF);
                compare(error_o, 1, "busy refusal");
                compare(gc_grp_o, ms[i], "service kept");
                cmd(8'h08, 8'h0A, 8'h01);
                compare(xchg_in_o, 1, "exchange while busy");
            end
            for (n = 0; n < 40 && busy_o !== 1'b0; n++) @(posedge clock_i);
            #1;
            if (busy_o !== 1'b0) begin
                compare(busy_o, 0, "completion timeout");
                results();
            end
            reg_rd(`FGCU_OFF_RESULT, 32'h0000_0040 + i, "result");
            reg_rd(`FGCU_OFF_FROZEN, fz[i], "frozen groups");
            reg_rd(`FGCU_OFF_SYNCED, sy[i], "synced groups");
        end
        clear_err();
    endtask : t_gc
    task t_err;
        cmd(8'h07, 8'h0A, 8'h01);
        reg_rd(`FGCU_OFF_STATUS, 32'h0000_0015, "bad channel");
        clear_err();
        reg_wr(`FGCU_OFF_CTRL, 32'h0000_0005);
        cmd(8'h09, 8'h0A, 8'h01);
        compare({error_o, xchg_in_o}, 2'b10, "channel unassigned");
        clear_err();
        cmd(8'h08, 8'h0A, 8'h02);
        compare(xin_g, 8'h02, "other channel");
        reg_wr(`FGCU_OFF_CTRL, 32'h0000_0007);
        cmd(8'h09, 8'h11, 8'h01);
        reg_rd(`FGCU_OFF_STATUS, 32'h0000_0045, "bad code");
        clear_err();
        cmd(8'h09, 8'h0D, 8'h00);
        compare({busy_o, gc_req_o}, 0, "empty global control");
        reg_rd(`FGCU_OFF_RESULT, `FGCU_RES_EMPTY, "empty result");
        reg_rd(`FGCU_OFF_COUNT, 32'h0004_000D, "command counts");
    endtask : t_err
    task t_auto;
        for (int i = 0; i < 3; i++) begin
            if (i == 2) reg_wr(`FGCU_OFF_CTRL, 32'h0000_0006);
            @(posedge clock_i);
            cycle_start_i <= (i != 1);
            cycle_end_i <= (i == 1);
            @(posedge clock_i);
            {cycle_start_i, cycle_end_i} <= 2'b00;
            #1;
            compare({xchg_in_o, xin_g}, (i == 0) ? 9'h1FF : 9'h000, "auto input copy");
            compare({xchg_out_o, xout_g}, (i == 1) ? 9'h1FF : 9'h000, "auto output copy");
        end
        reg_wr(`FGCU_OFF_CTRL, 32'h0000_0007);
        @(posedge clock_i);
        {ce_i, cycle_start_i} <= 2'b01;
        @(posedge clock_i);
        {ce_i, cycle_start_i} <= 2'b10;
        #1;
        compare(xchg_in_o, 0, "enable low freezes copy");
    endtask : t_auto
    initial begin
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_exchange();
        t_gc();
        t_err();
        t_auto();
        results();
    end
endmodule : tb_top
`default_nettype wire
